/* File: src/isf_pkg.sv */
/*
 * Constants for the two-wire bus status flag block.
 * Assumes one instance per bus channel; no timescale here.
 */
package isf_pkg;
  localparam logic [31:0] ISF_STATUS0_ADDR = 32'hFFFFF342;
  localparam logic [31:0] ISF_STATUS1_ADDR = 32'hFFFFF352;
  localparam logic [7:0] ISF_STATUS_RST = 8'h00;
  localparam int ISF_B_MST = 7;
  localparam int ISF_B_ALD = 6;
  localparam int ISF_B_EXC = 5;
  localparam int ISF_B_COI = 4;
  localparam int ISF_B_TRC = 3;
  localparam int ISF_B_ACK = 2;
  localparam int ISF_B_STD = 1;
  localparam int ISF_B_SPD = 0;
  localparam logic [3:0] ISF_CNT_ADDR = 4'h8;
  localparam logic [3:0] ISF_CNT_ACK = 4'h9;
  localparam logic [3:0] ISF_CNT_FIRST = 4'h1;
  localparam logic [3:0] ISF_CNT_RST = 4'h0;
  localparam logic [3:0] ISF_EXT_LO = 4'h0;
  localparam logic [3:0] ISF_EXT_HI = 4'hF;
endpackage

/* File: src/isf_status_flags.sv */
/*
 * Status flag logic of one two-wire bus channel.
 * Assumes start/stop detection, arbitration and control events arrive
 * as one-cycle pulses on clk_i; serial clock is link_clk_i.
 */
`timescale 1ns/1ns
module isf_status_flags
  import isf_pkg::*;
(
  // Core clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial link
  input wire logic link_clk_i,
  input wire logic sda_i,
  // Bus events from the unit
  input wire logic start_gen_i,
  input wire logic start_det_i,
  input wire logic stop_det_i,
  input wire logic arb_lost_i,
  // Control bits
  input wire logic rel_wr_i,
  input wire logic unit_en_i,
  input wire logic [7:0] own_slave_addr_i,
  // Register access
  input wire logic rd_en_i,
  input wire logic rd_bit_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bitop_other_i,
  // Results
  output logic [7:0] status_o,
  output logic [7:0] rd_data_o,
  output logic sda_oe_o
);

  typedef struct packed {
    logic [7:0] sh;
    logic tog;
  } isf_link_t;

  typedef struct packed {
    logic tog_m;
    logic tog_s;
    logic tog_p;
    logic [7:0] byte_v;
    logic [3:0] cnt;
    logic first;
    logic en_d;
    logic [7:0] flags;
    logic [7:0] rd_data;
    logic oe;
  } isf_core_t;

  isf_link_t lk_r, lk_nxt;
  isf_core_t st_r, st_nxt;

  // Link side: shift each bit on the rising serial clock, flag it by toggle
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.sh = {lk_r.sh[6:0], sda_i};
    lk_nxt.tog = ~lk_r.tog;
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  logic bit_ev;
  logic [3:0] cnt_new;
  logic [7:0] byte_new;
  logic en_fall;
  logic clr_com;

  assign bit_ev = st_r.tog_s ^ st_r.tog_p;
  assign en_fall = st_r.en_d & ~unit_en_i;
  assign clr_com = stop_det_i | rel_wr_i | en_fall;
  // Shift value is stable for a whole serial period once the toggle lands
  assign byte_new = lk_r.sh;
  assign cnt_new = (st_r.cnt == ISF_CNT_ACK) ? ISF_CNT_FIRST : st_r.cnt + 4'h1;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tog_m = lk_r.tog;
    st_nxt.tog_s = st_r.tog_m;
    st_nxt.tog_p = st_r.tog_s;
    st_nxt.en_d = unit_en_i;
    if (bit_ev) begin
      st_nxt.cnt = cnt_new;
      st_nxt.byte_v = byte_new;
      if (cnt_new == ISF_CNT_FIRST) begin
        st_nxt.flags[ISF_B_ACK] = 1'b0;
        if (st_r.first && (st_r.cnt == ISF_CNT_ACK)) begin
          st_nxt.first = 1'b0;
          st_nxt.flags[ISF_B_STD] = 1'b0;
        end
      end
      if ((cnt_new == ISF_CNT_ADDR) && st_r.first) begin
        if ((byte_new[7:4] == ISF_EXT_LO) || (byte_new[7:4] == ISF_EXT_HI)) begin
          st_nxt.flags[ISF_B_EXC] = 1'b1;
        end
        if (byte_new[7:1] == own_slave_addr_i[7:1]) begin
          st_nxt.flags[ISF_B_COI] = 1'b1;
        end
        if (!st_r.flags[ISF_B_MST] && byte_new[0]) begin
          st_nxt.flags[ISF_B_TRC] = 1'b1;
        end
      end
      if ((cnt_new == ISF_CNT_ACK) && !byte_new[0]) begin
        st_nxt.flags[ISF_B_ACK] = 1'b1;
      end
    end
    // Read clear first so a same-cycle loss still lands
    if (rd_en_i || bitop_other_i || en_fall) begin
      st_nxt.flags[ISF_B_ALD] = 1'b0;
    end
    if (arb_lost_i) begin
      st_nxt.flags[ISF_B_ALD] = 1'b1;
    end
    if (start_gen_i) begin
      st_nxt.flags[ISF_B_MST] = 1'b1;
      st_nxt.flags[ISF_B_TRC] = 1'b1;
    end
    if (start_det_i) begin
      st_nxt.cnt = ISF_CNT_RST;
      st_nxt.first = 1'b1;
      st_nxt.flags[ISF_B_STD] = 1'b1;
      st_nxt.flags[ISF_B_SPD] = 1'b0;
      st_nxt.flags[ISF_B_EXC] = 1'b0;
      st_nxt.flags[ISF_B_COI] = 1'b0;
    end
    // Loss and stop beat a same-cycle own start: bus is not ours then
    if (clr_com || arb_lost_i) begin
      st_nxt.flags[ISF_B_MST] = 1'b0;
      st_nxt.flags[ISF_B_TRC] = 1'b0;
    end
    if (clr_com) begin
      st_nxt.first = 1'b0;
      st_nxt.flags[ISF_B_EXC] = 1'b0;
      st_nxt.flags[ISF_B_COI] = 1'b0;
      st_nxt.flags[ISF_B_ACK] = 1'b0;
      st_nxt.flags[ISF_B_STD] = 1'b0;
    end
    if (stop_det_i) begin
      st_nxt.flags[ISF_B_SPD] = 1'b1;
    end
    if (en_fall) begin
      st_nxt.flags[ISF_B_SPD] = 1'b0;
    end
    // Read path only; no write port exists for this register
    if (rd_en_i) begin
      if (rd_bit_i) begin
        st_nxt.rd_data = {7'h00, st_r.flags[bit_sel_i]};
      end else begin
        st_nxt.rd_data = st_r.flags;
      end
    end
    st_nxt.oe = st_nxt.flags[ISF_B_TRC];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status_o = st_r.flags;
  assign rd_data_o = st_r.rd_data;
  assign sda_oe_o = st_r.oe;

  a_mst_set_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_gen_i && !arb_lost_i && !stop_det_i && !rel_wr_i && !en_fall |=> status_o[ISF_B_MST])
    else $error("master flag not set by own start");

  a_mst_clr_evt: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (stop_det_i || rel_wr_i || $fell(unit_en_i)) |=> !status_o[ISF_B_MST])
    else $error("master flag not cleared");

  a_arb_loss_pair: assert property (@(posedge clk_i) disable iff (!nrst_i)
    arb_lost_i |=> status_o[ISF_B_ALD] && !status_o[ISF_B_MST])
    else $error("arb loss did not set lost and clear master");

  a_ald_no_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !status_o[ISF_B_ALD] && !arb_lost_i |=> !status_o[ISF_B_ALD])
    else $error("arb lost flag rose without loss");

  a_ald_read_clr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_en_i || bitop_other_i) && !arb_lost_i |=> !status_o[ISF_B_ALD])
    else $error("arb lost flag not cleared by access");

  a_rd_byte_val: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_en_i && !rd_bit_i |=> rd_data_o == $past(status_o))
    else $error("byte read returned wrong value");

  a_rd_bit_val: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_en_i && rd_bit_i |=> rd_data_o == {7'h00, $past(status_o[bit_sel_i])})
    else $error("bit read returned wrong value");

  a_addr_clr_evt: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (start_det_i || stop_det_i || rel_wr_i) |=>
      !status_o[ISF_B_EXC] && !status_o[ISF_B_COI])
    else $error("ext code or match not cleared");

  a_std_set_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_det_i && !stop_det_i && !rel_wr_i && !en_fall |=> status_o[ISF_B_STD] ##1
      (status_o[ISF_B_STD] || $past(clr_com) || $past(bit_ev)))
    else $error("start flag not set");

  a_oe_tracks_trc: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sda_oe_o == status_o[ISF_B_TRC])
    else $error("data drive enable differs from xmit flag");

  // Set and clear conditions, one or more properties per flag edge except the stop flag, which has none
  a_exc_set_ext: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_ev && st_r.first && (cnt_new == ISF_CNT_ADDR) && !start_det_i && !clr_com &&
      ((byte_new[7:4] == ISF_EXT_LO) || (byte_new[7:4] == ISF_EXT_HI)) |=> status_o[ISF_B_EXC])
    else $error("ext code flag not set");

  a_exc_no_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !status_o[ISF_B_EXC] && !(bit_ev && (cnt_new == ISF_CNT_ADDR)) |=> !status_o[ISF_B_EXC])
    else $error("ext code flag rose outside the address byte");

  a_coi_set_match: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_ev && st_r.first && (cnt_new == ISF_CNT_ADDR) && !start_det_i && !clr_com &&
      (byte_new[7:1] == own_slave_addr_i[7:1]) |=> status_o[ISF_B_COI])
    else $error("addr match flag not set");

  a_coi_no_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !status_o[ISF_B_COI] && !(bit_ev && (cnt_new == ISF_CNT_ADDR)) |=> !status_o[ISF_B_COI])
    else $error("addr match flag rose outside the address byte");

  a_addr_en_fall: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_fall |=> !status_o[ISF_B_EXC] && !status_o[ISF_B_COI])
    else $error("ext code or match kept after disable");

  a_ack_set_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_ev && (cnt_new == ISF_CNT_ACK) && !byte_new[0] && !clr_com |=> status_o[ISF_B_ACK])
    else $error("ack flag not set");

  a_ack_no_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !status_o[ISF_B_ACK] && !(bit_ev && (cnt_new == ISF_CNT_ACK)) |=> !status_o[ISF_B_ACK])
    else $error("ack flag rose outside the ack slot");

  a_ack_clr_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_ev && (cnt_new == ISF_CNT_FIRST) |=> !status_o[ISF_B_ACK])
    else $error("ack flag kept into the next byte");

  a_ack_clr_evt: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clr_com |=> !status_o[ISF_B_ACK])
    else $error("ack flag not cleared by stop, release or disable");

  a_cnt_in_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_r.cnt <= ISF_CNT_ACK)
    else $error("bit counter past the ack slot");

  a_std_clr_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_ev && st_r.first && (st_r.cnt == ISF_CNT_ACK) && !start_det_i |=> !status_o[ISF_B_STD])
    else $error("start flag kept after the address byte");

  a_std_clr_evt: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clr_com |=> !status_o[ISF_B_STD])
    else $error("start flag not cleared by stop, release or disable");

  a_std_no_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !status_o[ISF_B_STD] && !start_det_i |=> !status_o[ISF_B_STD])
    else $error("start flag rose without a start");

  a_trc_set_gen: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_gen_i && !clr_com && !arb_lost_i |=> status_o[ISF_B_TRC])
    else $error("xmit flag not set by own start");

  a_trc_set_slave: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bit_ev && st_r.first && (cnt_new == ISF_CNT_ADDR) && byte_new[0] &&
      !status_o[ISF_B_MST] && !clr_com && !arb_lost_i |=> status_o[ISF_B_TRC])
    else $error("xmit flag not set by read direction bit");

  a_trc_clr_evt: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clr_com || arb_lost_i |=> !status_o[ISF_B_TRC])
    else $error("xmit flag not cleared");

  a_mst_no_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !status_o[ISF_B_MST] && !start_gen_i |=> !status_o[ISF_B_MST])
    else $error("master flag rose without own start");

  a_ald_en_fall: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_fall && !arb_lost_i |=> !status_o[ISF_B_ALD])
    else $error("arb lost flag kept after disable");

  a_rd_data_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without a read");

  a_rd_bit_upper: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_en_i && rd_bit_i |=> rd_data_o[7:1] == 7'h00)
    else $error("bit read left upper bits set");

  a_status_no_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(start_gen_i || start_det_i || stop_det_i || arb_lost_i || rel_wr_i || rd_en_i ||
      bitop_other_i || en_fall || bit_ev) |=> $stable(status_o))
    else $error("status moved without a hardware event");

  // No disable here: the flops must already be clear while reset is held
  a_reset_zero: assert property (@(posedge clk_i)
    !nrst_i |-> (status_o == ISF_STATUS_RST) && (rd_data_o == 8'h00) && !sda_oe_o)
    else $error("outputs not clear during reset");

endmodule

/* File: tb/isf_bus_party.sv */
/*
 * Far-side bus party: drives the serial clock and data.
 * Assumes the bench calls send_byte; both lines idle high by pull-up.
 */
`timescale 1ns/1ns
module isf_bus_party (
  // Serial link
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // MSB first, then the ack slot; clock stands still between frames
  task automatic send_byte(input logic [7:0] b, input logic ack_low);
    logic [8:0] v;
    v = {b, !ack_low};
    #3;
    for (int i = 8; i >= 0; i--) begin
      #80 scl_o = 1'b0;
      sda_o = v[i];
      #80 scl_o = 1'b1;
    end
    // Released line goes back to the pull-up level
    #80 sda_o = 1'b1;
  endtask
endmodule

/* File: tb/test_isf_status_flags.sv */
/*
 * Bench for the status flag block with a far-side bus party.
 * Assumes flags update at the core edge after each event pulse.
 */
`timescale 1ns/1ns
module test_isf_status_flags;
  import isf_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b1;
  logic [5:0] ev = 6'h00;
  logic unit_en = 1'b1;
  logic rd_en = 1'b0;
  logic rd_bit = 1'b0;
  logic [2:0] sel = 3'h0;
  logic scl;
  logic sda;
  logic [7:0] status;
  logic [7:0] rd_data;
  logic oe;
  int num_errors = 0;
  int checks_done = 0;
  // Event pulses {gen, det, stop, arb, rel, bitop} beside expected flags
  logic [13:0] rows [8] = '{14'h2088, 14'h0440, 14'h0100, 14'h2088,
                            14'h0801, 14'h1002, 14'h208A, 14'h0200};

  always #5 clk_i = ~clk_i;

  isf_bus_party isf_bus_party_inst (.scl_o(scl), .sda_o(sda));
  isf_status_flags isf_status_flags_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(scl), .sda_i(sda),
    .start_gen_i(ev[5]), .start_det_i(ev[4]), .stop_det_i(ev[3]),
    .arb_lost_i(ev[2]), .rel_wr_i(ev[1]), .unit_en_i(unit_en),
    .own_slave_addr_i(8'hA4), .rd_en_i(rd_en), .rd_bit_i(rd_bit),
    .bit_sel_i(sel), .bitop_other_i(ev[0]), .status_o(status),
    .rd_data_o(rd_data), .sda_oe_o(oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input logic [5:0] e);
    @(negedge clk_i);
    ev = e;
    @(negedge clk_i);
    ev = 6'h00;
  endtask

  task automatic rd(input logic b, input logic [2:0] s);
    @(negedge clk_i);
    rd_en = 1'b1;
    rd_bit = b;
    sel = s;
    @(negedge clk_i);
    rd_en = 1'b0;
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bound well above the three serial bytes plus event traffic
  initial begin
    #50000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    // A real falling edge, so both domains see their async reset
    #1 nrst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    nrst_i = 1'b1;
    chk(status, 8'h00);
    foreach (rows[i]) begin
      pulse(rows[i][13:8]);
      chk(status, rows[i][7:0]);
    end
    pulse(6'h04);
    rd(1'b1, 3'h6);
    chk(rd_data, 8'h01);
    chk(status, 8'h00);
    pulse(6'h04);
    rd(1'b0, 3'h0);
    chk(rd_data, 8'h40);
    chk(status, 8'h00);
    // Slave address byte with read direction, then one data byte
    pulse(6'h10);
    isf_bus_party_inst.send_byte(8'hA5, 1'b1);
    repeat (5) @(negedge clk_i);
    chk(status, 8'h1E);
    chk({7'h00, oe}, 8'h01);
    isf_bus_party_inst.send_byte(8'h00, 1'b0);
    repeat (5) @(negedge clk_i);
    chk(status, 8'h18);
    pulse(6'h08);
    chk(status, 8'h01);
    pulse(6'h10);
    isf_bus_party_inst.send_byte(8'hF0, 1'b0);
    repeat (5) @(negedge clk_i);
    chk(status, 8'h22);
    unit_en = 1'b0;
    @(negedge clk_i);
    chk(status, 8'h00);
    unit_en = 1'b1;
    pulse(6'h20);
    nrst_i = 1'b0;
    @(negedge clk_i);
    chk(status, 8'h00);
    nrst_i = 1'b1;
    end_of_test();
  end
endmodule
